// [rtl/tecl_pkg.sv]
// package of constants for the tape error check logic
package tecl_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_FLAGS  = 8'h00;
	localparam logic [7:0] OFF_CTRL   = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	// flag bit positions
	localparam int F_CONVERT = 0;
	localparam int F_VRC     = 1;
	localparam int F_MTE     = 2;
	localparam int F_ZWC     = 3;
	localparam int F_REJECT  = 4;
	localparam int F_PHASE   = 5;
	localparam int F_BUSOUT  = 6;
	localparam int F_EQUIP   = 7;
	localparam int F_DATA    = 8;
	localparam int NFLAGS    = 9;
	// control bit positions
	localparam int C_ERR_RST  = 0;
	localparam int C_SYS_RST  = 1;
	localparam int C_STOP     = 2;
	localparam int C_SOC_MTE  = 3;
	localparam int C_SOC_END  = 4;
	localparam int C_NRZ_ODD  = 5;
	localparam int C_REJ_JMP  = 6;
	localparam int C_TWO_CH   = 7;
	localparam int C_DIAG     = 8;
	localparam int NCTRL      = 9;
	localparam logic [NCTRL-1:0] CTRL_RESET = 9'h000;
	// status bit positions
	localparam int S_HALT    = 0;
	localparam int S_STOPREQ = 1;
	localparam int S_OPEND   = 2;
	// timing counts
	localparam int TM_BYTES   = 35;
	localparam int GAP_CELLS  = 48;
	localparam int GAP_TENTHS = 2;   // .2 inches, in tenths
	localparam logic [8:0] CRC_MATCH = 9'h1D7; // 111010111
	// command codes
	localparam logic [3:0] CMD_WRITE  = 4'h1;
	localparam logic [3:0] CMD_WTM    = 4'h2;
	localparam logic [3:0] CMD_ERASE  = 4'h3;
	localparam logic [3:0] CMD_SECERA = 4'h4;
	localparam logic [3:0] CMD_RSV    = 4'h5;
	localparam logic [3:0] CMD_REL    = 4'h6;
	localparam logic [3:0] CMD_RDB    = 4'h7;
	localparam logic [3:0] CMD_RDF    = 4'h8;
	localparam logic [3:0] CMD_SENSE  = 4'h9;
	localparam logic [3:0] CMD_NOP    = 4'h0;
	// tape-mark check states
	typedef enum logic [1:0] {
		TECL_IDLE = 2'b00,
		TECL_WAIT = 2'b01,
		TECL_GAP  = 2'b10
	} tecl_tm_t;
endpackage : tecl_pkg

// [rtl/tecl_top.sv]
// tape error check logic with its AXI4-Lite register slave
// How it works
// - convert check when convert clock stands at 3, 6 or 9 at read end
// - on phase write, skew buffer check without envelope check sets vertical check
// - on phase read, even parity sets vertical check; nrz parity per mode
// - velocity error on any write, or track 2 velocity fail on phase write, sets multi-track
// - more than one dead-track position on sets multi-track in phase mode
// - write ending with no byte transferred raises zero word count
// - write, tape mark or erase gap to protected drive is rejected
// - with reject jumper fitted, unknown command codes are rejected
// - secure erase not chained to erase gap, or with tape indicate, rejected
// - reserve or release rejected without two-channel switch or if not first
// - read backward in diagnostic nine-track mode needs diagnostic latch
// - first and second phase errors both flag phase check
// - bus-out check on bad parity at command-out, and service-out for writes
// - phase tape mark not read back within 35 byte times: equipment check
// - no gap within .2 inches after phase record or mark: equipment check
// - phase write with no data on the read head: equipment check
// - nine-track nrz read ends with cyclic register not 111010111: data check
// - no gap within 48 bit cells after end of data: data check
// - block seen again after gap, or gap before end of data: data check
// - error reset clears flags; system reset clears all check circuits, and the control register only when it comes from the pin
// - stop ends the operation at its next normal termination point
// - stop-on-check halts clock on multi-track or longitudinal error
// - end-data stop halts on end-data check or cyclic check error
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module tecl_top (
	// clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// axi4-lite slave
	input  wire logic [7:0]                s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output var  logic                      s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output var  logic                      s_axi_wready,
	output var  logic [1:0]                s_axi_bresp,
	output var  logic                      s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [7:0]                s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output var  logic                      s_axi_arready,
	output var  logic [31:0]               s_axi_rdata,
	output var  logic [1:0]                s_axi_rresp,
	output var  logic                      s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	// datapath mode and operation, same clock
	input  wire logic                      pe_mode,
	input  wire logic                      nine_track,
	input  wire logic                      op_write,
	input  wire logic                      op_read,
	input  wire logic                      op_wtm,
	input  wire logic                      op_end,
	input  wire logic                      convert_read,
	input  wire logic [3:0]                convert_clock,
	input  wire logic                      byte_xfer,
	// datapath check conditions, same clock
	input  wire logic                      skew_chk,
	input  wire logic                      envelope_chk,
	input  wire logic                      rw_parity_odd,
	input  wire logic                      rw_parity_valid,
	input  wire logic                      velocity_err,
	input  wire logic                      track2_vel_fail,
	input  wire logic [8:0]                dead_track,
	input  wire logic                      phase_err1,
	input  wire logic                      phase_err2,
	input  wire logic                      long_err,
	input  wire logic [8:0]                crc_reg,
	input  wire logic                      tm_readback_ok,
	input  wire logic                      byte_time,
	input  wire logic                      tenth_inch,
	input  wire logic                      bit_cell,
	input  wire logic                      gap_detect,
	input  wire logic                      block_detect,
	input  wire logic                      end_of_data,
	input  wire logic                      read_data_seen,
	input  wire logic                      end_data_chk,
	// command decode from the channel, same clock
	input  wire logic                      cmd_valid,
	input  wire logic [3:0]                cmd_code,
	input  wire logic                      cmd_known,
	input  wire logic                      cmd_chained_erase,
	input  wire logic                      cmd_first,
	input  wire logic                      file_protect,
	input  wire logic                      tape_indicate,
	input  wire logic                      nine_track_diag_mode,
	input  wire logic                      io_parity_ok,
	input  wire logic                      command_out,
	input  wire logic                      service_out,
	// results
	output var  logic [tecl_pkg::NFLAGS-1:0] err_flags,
	output var  logic                      cmd_reject,
	output var  logic                      clock_halt,
	output var  logic                      op_terminate,
	output var  logic                      unit_reset_n
);
	import tecl_pkg::*;

	logic [NFLAGS-1:0] flag_reg;
	logic [NFLAGS-1:0] flag_next;
	logic [NCTRL-1:0]  ctrl_reg;
	logic              halt_reg;
	logic              stop_req_reg;
	logic              zbytes_reg;
	logic              ebit_next;
	logic              rst_all;
	logic              err_clr;
	tecl_tm_t          tm_state_reg;
	logic [5:0]        tm_cnt_reg;
	logic [5:0]        gap_cnt_reg;
	logic [5:0]        cell_cnt_reg;
	logic              eod_wait_reg;
	logic              after_gap_reg;
	logic              seen_eod_reg;
	logic              equip_tm;
	logic              equip_gap;
	logic              data_gap;

	// clears the lowest set bit, so the dead-track check needs no ones count
	function automatic logic multi_on(input logic [8:0] v);
		return (v & (v - 9'h001)) != 9'h000;
	endfunction : multi_on

	// system reset from the bus or the pin; both restart the check circuits, only the pin the bus side, control register and outputs
	assign rst_all = !aresetn || ctrl_reg[C_SYS_RST];
	assign err_clr = rst_all || ctrl_reg[C_ERR_RST];

	// axi write side: accept address and data in either order
	logic       aw_held_reg;
	logic       w_held_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic       wr_fire;
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg   <= 1'b0;
			w_held_reg    <= 1'b0;
			aw_addr_reg   <= 8'h00;
			w_data_reg    <= 32'h0000_0000;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
		end else begin
			s_axi_awready <= !aw_held_reg && !s_axi_awready;
			s_axi_wready  <= !w_held_reg && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg   <= 1'b1;
				aw_addr_reg   <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg   <= 1'b1;
				w_data_reg   <= s_axi_wdata;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_reg == OFF_CTRL || aw_addr_reg == OFF_FLAGS) ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// control register; the two reset bits self-clear after one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= CTRL_RESET;
		end else begin
			ctrl_reg[C_ERR_RST] <= 1'b0;
			ctrl_reg[C_SYS_RST] <= 1'b0;
			if (wr_fire && aw_addr_reg == OFF_CTRL && s_axi_wstrb[0])
				ctrl_reg[7:0] <= w_data_reg[7:0];
			if (wr_fire && aw_addr_reg == OFF_CTRL && s_axi_wstrb[1])
				ctrl_reg[8] <= w_data_reg[8];
		end
	end

	// axi read side: one cycle from address to data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= 2'h0;
				unique case (s_axi_araddr)
					OFF_FLAGS:  s_axi_rdata <= {23'h000000, flag_reg};
					OFF_CTRL:   s_axi_rdata <= {23'h000000, ctrl_reg};
					OFF_STATUS: s_axi_rdata <= {29'h00000000, op_terminate, stop_req_reg, halt_reg};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'h2;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// zero word count tracker: any channel byte during the write clears it
	always_ff @(posedge aclk) begin
		if (rst_all || (op_end && op_write))
			zbytes_reg <= 1'b1;
		else if (byte_xfer)
			zbytes_reg <= 1'b0;
	end

	// tape mark readback and post-write gap watchdogs
	always_ff @(posedge aclk) begin
		if (rst_all) begin
			tm_state_reg <= TECL_IDLE;
			tm_cnt_reg   <= 6'h00;
			gap_cnt_reg  <= 6'h00;
		end else begin
			unique case (tm_state_reg)
				TECL_IDLE: begin
					tm_cnt_reg  <= 6'h00;
					gap_cnt_reg <= 6'h00;
					if (pe_mode && op_wtm && !op_end)
						tm_state_reg <= TECL_WAIT;
					else if (pe_mode && (op_write || op_wtm) && op_end)
						tm_state_reg <= TECL_GAP;
				end
				TECL_WAIT: begin
					if (tm_readback_ok || tm_cnt_reg == 6'(TM_BYTES))
						tm_state_reg <= TECL_GAP;
					else if (byte_time)
						tm_cnt_reg <= tm_cnt_reg + 6'h01;
				end
				TECL_GAP: begin
					if (gap_detect || gap_cnt_reg == 6'(GAP_TENTHS))
						tm_state_reg <= TECL_IDLE;
					else if (tenth_inch)
						gap_cnt_reg <= gap_cnt_reg + 6'h01;
				end
				default: tm_state_reg <= TECL_IDLE;
			endcase
		end
	end
	assign equip_tm  = tm_state_reg == TECL_WAIT && !tm_readback_ok && tm_cnt_reg == 6'(TM_BYTES);
	assign equip_gap = tm_state_reg == TECL_GAP && !gap_detect && gap_cnt_reg == 6'(GAP_TENTHS);

	// gap after end of data, counted in bit cells
	always_ff @(posedge aclk) begin
		if (rst_all) begin
			eod_wait_reg  <= 1'b0;
			cell_cnt_reg  <= 6'h00;
			after_gap_reg <= 1'b0;
			seen_eod_reg  <= 1'b0;
		end else begin
			if (end_of_data) begin
				eod_wait_reg <= 1'b1;
				seen_eod_reg <= 1'b1;
				cell_cnt_reg <= 6'h00;
			end else if (eod_wait_reg && (gap_detect || cell_cnt_reg == 6'(GAP_CELLS))) begin
				eod_wait_reg <= 1'b0;
			end else if (eod_wait_reg && bit_cell) begin
				cell_cnt_reg <= cell_cnt_reg + 6'h01;
			end
			if (gap_detect)
				after_gap_reg <= 1'b1;
			else if (op_end)
				after_gap_reg <= 1'b0;
			if (op_end)
				seen_eod_reg <= 1'b0;
		end
	end
	assign data_gap = eod_wait_reg && !gap_detect && cell_cnt_reg == 6'(GAP_CELLS);

	// command reject decode
	always_comb begin
		ebit_next = 1'b0;
		if (cmd_valid) begin
			if (file_protect && (cmd_code == CMD_WRITE || cmd_code == CMD_WTM || cmd_code == CMD_ERASE))
				ebit_next = 1'b1;
			if (ctrl_reg[C_REJ_JMP] && !cmd_known)
				ebit_next = 1'b1;
			if (cmd_code == CMD_SECERA && (!cmd_chained_erase || tape_indicate))
				ebit_next = 1'b1;
			if ((cmd_code == CMD_RSV || cmd_code == CMD_REL) && (!ctrl_reg[C_TWO_CH] || !cmd_first))
				ebit_next = 1'b1;
			if (cmd_code == CMD_RDB && nine_track_diag_mode && !ctrl_reg[C_DIAG])
				ebit_next = 1'b1;
		end
	end

	// new error events this cycle
	always_comb begin
		flag_next = '0;
		flag_next[F_CONVERT] = convert_read && op_end &&
			(convert_clock == 4'h3 || convert_clock == 4'h6 || convert_clock == 4'h9);
		flag_next[F_VRC] = (pe_mode && op_write && skew_chk && !envelope_chk) ||
			(rw_parity_valid && op_read && pe_mode && !rw_parity_odd) ||
			(rw_parity_valid && !pe_mode && (rw_parity_odd == ctrl_reg[C_NRZ_ODD]));
		flag_next[F_MTE] = (op_write && velocity_err) ||
			(pe_mode && op_write && track2_vel_fail) ||
			(pe_mode && (op_read || op_write) && multi_on(dead_track)) ||
			(!pe_mode && long_err);
		flag_next[F_ZWC] = op_write && op_end && zbytes_reg && !byte_xfer;
		flag_next[F_REJECT] = ebit_next;
		flag_next[F_PHASE] = phase_err1 || phase_err2;
		flag_next[F_BUSOUT] = !io_parity_ok && (command_out ||
			(service_out && (op_write || op_wtm)));
		flag_next[F_EQUIP] = equip_tm || equip_gap ||
			(pe_mode && op_write && op_end && !read_data_seen);
		flag_next[F_DATA] = (nine_track && !pe_mode && op_read && op_end && crc_reg != CRC_MATCH) ||
			data_gap ||
			(block_detect && after_gap_reg) ||
			(gap_detect && !seen_eod_reg && op_read && !end_of_data) ||
			(pe_mode && end_data_chk);
	end

	// sticky flags; a new event in the clearing cycle still lands
	always_ff @(posedge aclk) begin
		if (err_clr)
			flag_reg <= flag_next;
		else
			flag_reg <= flag_reg | flag_next;
	end

	// stop-on-check clock halt, held until an error reset
	always_ff @(posedge aclk) begin
		if (err_clr)
			halt_reg <= 1'b0;
		else if (ctrl_reg[C_SOC_MTE] && flag_next[F_MTE])
			halt_reg <= 1'b1;
		else if (ctrl_reg[C_SOC_END] && ((pe_mode && end_data_chk) ||
			(!pe_mode && nine_track && op_read && op_end && crc_reg != CRC_MATCH)))
			halt_reg <= 1'b1;
	end

	// stop waits for the normal end of the running operation
	always_ff @(posedge aclk) begin
		if (rst_all) begin
			stop_req_reg <= 1'b0;
			op_terminate <= 1'b0;
		end else begin
			op_terminate <= stop_req_reg && op_end;
			if (stop_req_reg && op_end)
				stop_req_reg <= 1'b0;
			else if (ctrl_reg[C_STOP])
				stop_req_reg <= 1'b1;
		end
	end

	// registered outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_flags    <= '0;
			cmd_reject   <= 1'b0;
			clock_halt   <= 1'b0;
			unit_reset_n <= 1'b0;
		end else begin
			err_flags    <= flag_reg;
			cmd_reject   <= ebit_next;
			clock_halt   <= halt_reg;
			unit_reset_n <= !ctrl_reg[C_SYS_RST];
		end
	end

	// checks
	sequence s_tm_start;
		pe_mode && op_wtm && !op_end && tm_state_reg == TECL_IDLE;
	endsequence
	AST_CONVERT: assert property (@(posedge aclk) disable iff (!aresetn)
		convert_read && op_end && convert_clock == 4'h6 |=> flag_reg[F_CONVERT])
		else $error("convert check missed");
	AST_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
		flag_reg[F_PHASE] && !err_clr |=> flag_reg[F_PHASE])
		else $error("flag dropped without reset");
	AST_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_reg[C_ERR_RST] && flag_next == '0 |=> flag_reg == '0)
		else $error("error reset did not clear");
	AST_PROTECT: assert property (@(posedge aclk) disable iff (!aresetn)
		cmd_valid && file_protect && cmd_code == CMD_WRITE |=> cmd_reject)
		else $error("protected write not rejected");
	AST_TM: assert property (@(posedge aclk) disable iff (!aresetn || rst_all)
		s_tm_start ##1 (!tm_readback_ok && tm_cnt_reg != 6'(TM_BYTES)) |=> tm_state_reg == TECL_WAIT)
		else $error("tape mark wait ended early");
	AST_CRC: assert property (@(posedge aclk) disable iff (!aresetn)
		nine_track && !pe_mode && op_read && op_end && crc_reg != CRC_MATCH |=> flag_reg[F_DATA])
		else $error("crc data check missed");
	AST_STOP: assert property (@(posedge aclk) disable iff (!aresetn || rst_all)
		stop_req_reg && !op_end |=> !op_terminate)
		else $error("stop ended operation early");
	AST_HALT: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_reg[C_SOC_MTE] && flag_next[F_MTE] && !err_clr |=> ##1 clock_halt)
		else $error("no halt on multi-track error");
	AST_DEAD: assert property (@(posedge aclk) disable iff (!aresetn)
		pe_mode && op_read && dead_track == 9'h003 |=> flag_reg[F_MTE])
		else $error("dead track multi error missed");
endmodule : tecl_top
`default_nettype wire

// [test/tecl_tape_model.sv]
// tape-side model: unit timing pulses from a moving tape
`timescale 1ns/100ps
`default_nettype none
module tecl_tape_model (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// tape motion
	input  wire logic moving,
	// unit pulses, one cycle each
	output logic      byte_time,
	output logic      tenth_inch,
	output logic      bit_cell
);
	logic [7:0] cnt_reg;
	// pulses stand still while the tape is stopped, so no timer can creep on idle tape
	always_ff @(posedge aclk) begin
		if (!aresetn || !moving) begin
			cnt_reg <= 8'h00;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end
	// slow tenth-inch period keeps the gap timer well behind the tape mark count
	assign byte_time  = moving && (cnt_reg[1:0] == 2'h3);
	assign tenth_inch = moving && (cnt_reg == 8'hFF);
	assign bit_cell   = moving && cnt_reg[0];
endmodule : tecl_tape_model
`default_nettype wire

// [test/test_tape_error_check_logic.sv]
// self-checking bench for the tape error check logic
`timescale 1ns/100ps
`default_nettype none
module test_tape_error_check_logic;
	import tecl_pkg::*;
	localparam logic [7:0] PEW = 8'h03, PER = 8'h05, NW = 8'h02, NR = 8'h04;
	logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bq = 0, arv = 0, rq = 0, po = 0, cv = 0, mv = 0;
	logic        awr, wr, bv, arr, rv, rej, halt, term, urst, bt, tn, bc;
	logic        rej_seen = 0, term_seen = 0, urst_seen = 0;
	logic [7:0]  awa = 0, ara = 0, lv = 0;
	logic [31:0] wd = 0, rdt, rd;
	logic [1:0]  br, rr, resp;
	logic [15:0] ev = 0;
	logic [8:0]  dt = 0, crc = 0, flags;
	logic [3:0]  cc = 0, code = 0;
	logic [5:0]  cq = 0;
	int          mismatches = 0, tests_run = 0;
	always #25 aclk = ~aclk;
	tecl_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bq), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rq),
		.pe_mode(lv[0]), .nine_track(lv[3]), .op_write(lv[1]), .op_read(lv[2]), .op_wtm(lv[4]),
		.op_end(ev[10]), .convert_read(lv[5]), .convert_clock(cc), .byte_xfer(ev[11]), .skew_chk(ev[0]),
		.envelope_chk(ev[1]), .rw_parity_odd(po), .rw_parity_valid(ev[2]), .velocity_err(ev[3]),
		.track2_vel_fail(ev[4]), .dead_track(dt), .phase_err1(ev[5]), .phase_err2(ev[6]), .long_err(ev[7]),
		.crc_reg(crc), .tm_readback_ok(ev[13]), .byte_time(bt), .tenth_inch(tn), .bit_cell(bc),
		.gap_detect(ev[14]), .block_detect(ev[15]), .end_of_data(1'b0), .read_data_seen(lv[7]),
		.end_data_chk(ev[12]), .cmd_valid(cv), .cmd_code(code), .cmd_known(cq[0]), .cmd_chained_erase(cq[1]),
		.cmd_first(cq[2]), .file_protect(cq[3]), .tape_indicate(cq[4]), .nine_track_diag_mode(cq[5]),
		.io_parity_ok(~lv[6]), .command_out(ev[8]), .service_out(ev[9]), .err_flags(flags),
		.cmd_reject(rej), .clock_halt(halt), .op_terminate(term), .unit_reset_n(urst));
	tecl_tape_model u_tape (.aclk(aclk), .aresetn(aresetn), .moving(mv), .byte_time(bt),
		.tenth_inch(tn), .bit_cell(bc));
	// one-cycle outputs are caught here so a scenario can judge them afterwards
	always @(posedge aclk) begin
		if (rej === 1'b1) rej_seen = 1;
		if (term === 1'b1) term_seen = 1;
		if (urst === 1'b0) urst_seen = 1;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : chk
	// write and read address/data are held until each is taken, ready for the answer throughout
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic done;
		done = 0;
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		bq <= 1;
		while (!done) begin
			@(posedge aclk);
			if (awr) awv <= 0;
			if (wr) wv <= 0;
			if (bv === 1'b1) begin
				done = 1;
				resp = br;
			end
		end
		bq <= 0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		logic done;
		done = 0;
		@(posedge aclk);
		ara <= a;
		arv <= 1;
		rq <= 1;
		while (!done) begin
			@(posedge aclk);
			if (arr) arv <= 0;
			if (rv === 1'b1) begin
				done = 1;
				rd = rdt;
				resp = rr;
			end
		end
		rq <= 0;
	endtask : axi_rd
	// error reset keeps the mode bits, since it is one write to the shared control word
	task automatic clr_chk(input logic [31:0] ctrl);
		axi_wr(OFF_CTRL, ctrl | (32'h1 << C_ERR_RST));
		repeat (3) @(posedge aclk);
		chk(flags, 0);
		chk(halt, 0);
	endtask : clr_chk
	// one condition pulse under given levels; 9'h1FF as expectation skips the flag compare
	task automatic row(input logic [7:0] l, input logic [15:0] e, input logic [8:0] d, input logic p,
		input logic [8:0] c, input logic [3:0] k, input logic [8:0] exp, input logic hx, input logic [31:0] ctrl);
		@(posedge aclk);
		lv <= l;
		dt <= d;
		po <= p;
		crc <= c;
		cc <= k;
		@(posedge aclk);
		ev <= e;
		@(posedge aclk);
		ev <= 0;
		repeat (4) @(posedge aclk);
		if (exp !== 9'h1FF) chk(flags, exp);
		chk(halt, hx);
		lv <= 0;
		dt <= 0;
		clr_chk(ctrl);
	endtask : row
	task automatic cmd(input logic [3:0] k, input logic [5:0] q, input logic exp, input logic [31:0] ctrl);
		@(posedge aclk);
		code <= k;
		cq <= q;
		cv <= 1;
		rej_seen = 0;
		@(posedge aclk);
		cv <= 0;
		repeat (4) @(posedge aclk);
		chk(rej_seen, exp);
		chk(flags[F_REJECT], exp);
		clr_chk(ctrl);
	endtask : cmd
	task automatic t_stop;
		axi_wr(OFF_CTRL, 32'h1 << C_STOP);
		term_seen = 0;
		lv <= NR;
		repeat (5) @(posedge aclk);
		chk(term_seen, 0);
		ev <= 16'h0400;
		@(posedge aclk);
		ev <= 0;
		repeat (3) @(posedge aclk);
		chk(term_seen, 1);
		lv <= 0;
		clr_chk(0);
	endtask : t_stop
	task automatic t_tm;
		lv <= 8'h11;
		mv <= 1;
		repeat (100) @(posedge aclk);
		chk(flags[F_EQUIP], 0);
		repeat (80) @(posedge aclk);
		chk(flags[F_EQUIP], 1);
		lv <= 0;
		mv <= 0;
		clr_chk(0);
	endtask : t_tm
	task automatic t_sys;
		@(posedge aclk);
		ev <= 16'h0020;
		@(posedge aclk);
		ev <= 0;
		repeat (4) @(posedge aclk);
		chk(flags, 9'h020);
		urst_seen = 0;
		axi_wr(OFF_CTRL, 32'h1 << C_SYS_RST);
		repeat (3) @(posedge aclk);
		chk(urst_seen, 1);
		chk(flags, 0);
	endtask : t_sys
	task automatic conclude;
		$display("comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		axi_rd(OFF_CTRL);
		chk(rd, {23'h0, CTRL_RESET});
		axi_rd(8'h0C);
		chk(resp, 2'h2);
		axi_wr(OFF_STATUS, 0);
		chk(resp, 2'h2);
		for (int i = 0; i < 10; i++) row(8'h24, 16'h0400, 0, 0, 0, i, (i % 3 == 0 && i != 0), 0, 0);
		row(PEW, 16'h0001, 0, 0, 0, 0, 9'h002, 0, 0);
		row(PEW, 16'h0003, 0, 0, 0, 0, 9'h000, 0, 0);
		row(PER, 16'h0004, 0, 0, 0, 0, 9'h002, 0, 0);
		row(PER, 16'h0004, 0, 1, 0, 0, 9'h000, 0, 0);
		row(NR, 16'h0004, 0, 0, 0, 0, 9'h002, 0, 0);
		row(NW, 16'h0008, 0, 0, 0, 0, 9'h004, 0, 0);
		row(PEW, 16'h0010, 0, 0, 0, 0, 9'h004, 0, 0);
		row(PER, 16'h0000, 9'h011, 0, 0, 0, 9'h004, 0, 0);
		row(PER, 16'h0000, 9'h010, 0, 0, 0, 9'h000, 0, 0);
		row(PER, 16'h0020, 0, 0, 0, 0, 9'h020, 0, 0);
		row(PER, 16'h0040, 0, 0, 0, 0, 9'h020, 0, 0);
		row(8'h44, 16'h0100, 0, 0, 0, 0, 9'h040, 0, 0);
		row(8'h44, 16'h0200, 0, 0, 0, 0, 9'h000, 0, 0);
		row(8'h42, 16'h0200, 0, 0, 0, 0, 9'h040, 0, 0);
		row(PEW, 16'h0400, 0, 0, 0, 0, 9'h088, 0, 0);
		row(PEW, 16'h4000, 0, 0, 0, 0, 9'h000, 0, 0);
		row(PER, 16'h8000, 0, 0, 0, 0, 9'h100, 0, 0);
		row(PER, 16'h4000, 0, 0, 0, 0, 9'h100, 0, 0);
		row(NW, 16'h0400, 0, 0, 0, 0, 9'h008, 0, 0);
		row(8'h0C, 16'h0400, 0, 0, CRC_MATCH, 0, 9'h000, 0, 0);
		row(8'h0C, 16'h0400, 0, 0, 9'h1D6, 0, 9'h100, 0, 0);
		axi_wr(OFF_CTRL, 32'h1 << C_SOC_MTE);
		row(PER, 16'h0000, 9'h003, 0, 0, 0, 9'h004, 1, 32'h1 << C_SOC_MTE);
		row(NR, 16'h0080, 0, 0, 0, 0, 9'h004, 1, 32'h1 << C_SOC_MTE);
		axi_wr(OFF_CTRL, 32'h1 << C_SOC_END);
		row(PER, 16'h1000, 0, 0, 0, 0, 9'h1FF, 1, 32'h1 << C_SOC_END);
		row(8'h0C, 16'h0400, 0, 0, 9'h1D6, 0, 9'h100, 1, 32'h1 << C_SOC_END);
		axi_wr(OFF_CTRL, 0);
		cmd(CMD_WRITE, 6'h0F, 1, 0);
		cmd(CMD_WTM, 6'h0F, 1, 0);
		cmd(CMD_ERASE, 6'h0F, 1, 0);
		cmd(CMD_WRITE, 6'h07, 0, 0);
		cmd(4'hF, 6'h06, 0, 0);
		cmd(CMD_SECERA, 6'h05, 1, 0);
		cmd(CMD_SECERA, 6'h17, 1, 0);
		cmd(CMD_SECERA, 6'h07, 0, 0);
		cmd(CMD_RSV, 6'h07, 1, 0);
		cmd(CMD_RDB, 6'h27, 1, 0);
		axi_wr(OFF_CTRL, 32'h1C0);
		cmd(4'hF, 6'h06, 1, 32'h1C0);
		cmd(CMD_REL, 6'h07, 0, 32'h1C0);
		cmd(CMD_REL, 6'h03, 1, 32'h1C0);
		cmd(CMD_RDB, 6'h27, 0, 32'h1C0);
		axi_wr(OFF_CTRL, 0);
		t_stop();
		t_tm();
		t_sys();
		conclude();
	end
	initial begin
		#3000000;
		mismatches++;
		conclude();
	end
endmodule : test_tape_error_check_logic
`default_nettype wire
